// file: logic/mcxs_pkg.sv
// Shared constants and types for the instruction execute subset
package mcxs_pkg;
	localparam int PC_W     = 21;
	localparam int DADDR_W  = 12;
	localparam int STK_SLOTS = 31;
	localparam int SP_W     = 5;

	// Opcode patterns
	localparam logic [7:0]  OP_MUL_LIT  = 8'h0D;
	localparam logic [7:0]  OP_RET_LIT  = 8'h0C;
	localparam logic [6:0]  OP_MUL_REG  = 7'h01;
	localparam logic [6:0]  OP_NEG_REG  = 7'h36;
	localparam logic [4:0]  OP_REL_CALL = 5'h1B;
	localparam logic [3:0]  OP_NOP_HI   = 4'hF;
	localparam logic [15:0] OP_NOP      = 16'h0000;
	localparam logic [15:0] OP_POP      = 16'h0006;
	localparam logic [15:0] OP_PUSH     = 16'h0005;
	localparam logic [15:0] OP_SW_RESET = 16'h00FF;
	localparam logic [14:0] OP_INT_RET  = 15'h0008;

	// Field positions of the instruction word
	localparam int ACC_SEL_BIT = 8;
	localparam int FAST_BIT    = 0;

	// Addressing
	localparam logic [7:0] INDEXED_MAX  = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] SFR_BANK     = 4'hF;
	localparam logic [3:0] ACCESS_BANK  = 4'h0;

	// Status flag positions
	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N  = 4;

	// Values after reset and the PC step
	localparam logic [PC_W-1:0] PC_RST     = 21'h00_0000;
	localparam logic [7:0]      W_RST      = 8'h00;
	localparam logic [15:0]     PROD_RST   = 16'h0000;
	localparam logic [4:0]      STATUS_RST = 5'h00;
	localparam logic [3:0]      BSR_RST    = 4'h0;
	localparam logic [SP_W-1:0] SP_RST     = 5'h00;
	localparam logic [PC_W-1:0] PC_STEP    = 21'h00_0002;

	typedef enum logic [1:0] {QD, QR, QP, QW} mcxs_phase_type;

	typedef struct packed {
		logic [DADDR_W-1:0] addr;
		logic [7:0]         wdata;
		logic               we;
	} mcxs_dmem_type;

	typedef struct packed {
		logic [7:0] w;
		logic [4:0] status;
		logic [3:0] bank_select_reg;
	} mcxs_shadow_type;
endpackage

// file: logic/mcxs_core.sv
// Decode and execute of the multiply, negate, stack, call, reset and return group
// Summary of operation
// - literal multiply, product to pair, W kept
// - multiplies leave all status flags untouched
// - register multiply, operands unchanged, product pair
// - select bit 0 access bank, 1 uses bank
// - extended set: offset 95 or below indexed
// - negate register, write back, update five flags
// - pop discards top, previous entry becomes top
// - push places PC plus two on stack
// - relative call pushes, jumps by twice offset
// - relative call takes two cycles, second idle
// - software reset equals master clear, second quarter
// - interrupt return pops PC, sets priority enable
// - multiply completes in one cycle, writes Q4
`timescale 1ns/1ps
`default_nettype none
module mcxs_core (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rstn,
	// Program memory word at pc_ff
	input  wire logic [15:0]                     insn,
	output logic [mcxs_pkg::PC_W-1:0]            pc_ff,
	// Data memory
	output mcxs_pkg::mcxs_dmem_type              dmem_ff,
	input  wire logic [7:0]                      dmem_rdata,
	// Addressing context
	input  wire logic                            ext_set_en,
	input  wire logic [mcxs_pkg::DADDR_W-1:0]    index_base,
	// Interrupt return context
	input  wire mcxs_pkg::mcxs_shadow_type       shadow,
	input  wire logic                            exit_high_prio,
	// Core state
	output logic [7:0]                           w_ff,
	output logic [15:0]                          prod_ff,
	output logic [4:0]                           status_ff,
	output logic [3:0]                           bsr_ff,
	output logic                                 high_irq_en_ff,
	output logic                                 low_irq_en_ff,
	output logic                                 sw_reset_ff,
	output mcxs_pkg::mcxs_phase_type             phase_ff
);
	logic [15:0]                     ir_ff;
	logic                            flush_ff;
	logic [7:0]                      opnd_ff;
	logic [15:0]                     mul_ff;
	logic [4:0]                      flags_ff;
	logic [mcxs_pkg::SP_W-1:0]       sp_ff;
	logic [mcxs_pkg::PC_W-1:0]       stack_mem [1:mcxs_pkg::STK_SLOTS];

	function automatic logic [mcxs_pkg::DADDR_W-1:0] file_addr(
		input logic [15:0]                  word,
		input logic [3:0]                   bank,
		input logic                         ext,
		input logic [mcxs_pkg::DADDR_W-1:0] base
	);
		logic [7:0] f;
		f = word[7:0];
		if (word[mcxs_pkg::ACC_SEL_BIT]) begin
			file_addr = {bank, f};
		end else if (ext && f <= mcxs_pkg::INDEXED_MAX) begin
			file_addr = base + {4'h0, f};
		end else if (f < mcxs_pkg::ACCESS_SPLIT) begin
			file_addr = {mcxs_pkg::ACCESS_BANK, f};
		end else begin
			file_addr = {mcxs_pkg::SFR_BANK, f};
		end
	endfunction

	// Decode of the held word
	wire is_mul_lit  = ir_ff[15:8] == mcxs_pkg::OP_MUL_LIT;
	wire is_mul_reg  = ir_ff[15:9] == mcxs_pkg::OP_MUL_REG;
	wire is_neg      = ir_ff[15:9] == mcxs_pkg::OP_NEG_REG;
	wire is_pop      = ir_ff == mcxs_pkg::OP_POP;
	wire is_push     = ir_ff == mcxs_pkg::OP_PUSH;
	wire is_relative_call_op    = ir_ff[15:11] == mcxs_pkg::OP_REL_CALL;
	wire is_swrst    = ir_ff == mcxs_pkg::OP_SW_RESET;
	wire is_int_ret  = ir_ff[15:1] == mcxs_pkg::OP_INT_RET;
	wire is_ret_lit  = ir_ff[15:8] == mcxs_pkg::OP_RET_LIT;
	wire fast_ret    = ir_ff[mcxs_pkg::FAST_BIT];
	wire is_two_cyc  = is_relative_call_op | is_int_ret | is_ret_lit;

	// Phase strobes (one clock each)
	wire in_q1 = phase_ff == mcxs_pkg::QD;
	wire in_q2 = phase_ff == mcxs_pkg::QR;
	wire in_q3 = phase_ff == mcxs_pkg::QP;
	wire in_q4 = phase_ff == mcxs_pkg::QW;

	// Software reset fires in the second quarter
	wire do_swrst = in_q2 && is_swrst;

	// Zero word and F-prefixed words decode as nothing, so they only advance the PC
	wire nop_word = insn == mcxs_pkg::OP_NOP || insn[15:12] == mcxs_pkg::OP_NOP_HI;
	wire [15:0] next_ir = (flush_ff || nop_word) ? mcxs_pkg::OP_NOP : insn;

	wire [mcxs_pkg::PC_W-1:0] ret_addr = pc_ff + mcxs_pkg::PC_STEP;
	wire [mcxs_pkg::PC_W-1:0] rel_off  = {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0};
	wire [mcxs_pkg::PC_W-1:0] call_tgt = ret_addr + rel_off;
	wire [mcxs_pkg::PC_W-1:0] stack_top_entry      = stack_mem[sp_ff];

	wire [7:0]  mul_src  = is_mul_lit ? ir_ff[7:0] : opnd_ff;
	wire [15:0] mul_prod = {8'h00, w_ff} * {8'h00, mul_src};
	wire [7:0]  neg_res  = 8'h00 - opnd_ff;

	wire [4:0] neg_flags;
	assign neg_flags[mcxs_pkg::FLAG_C]  = opnd_ff == 8'h00;
	assign neg_flags[mcxs_pkg::FLAG_DC] = opnd_ff[3:0] == 4'h0;
	assign neg_flags[mcxs_pkg::FLAG_Z]  = neg_res == 8'h00;
	assign neg_flags[mcxs_pkg::FLAG_OV] = opnd_ff == 8'h80;
	assign neg_flags[mcxs_pkg::FLAG_N]  = neg_res[7];

	wire stk_push = in_q2 && (is_push || is_relative_call_op);
	wire stk_pop3 = in_q3 && is_pop;
	wire stk_pop4 = in_q4 && (is_int_ret || is_ret_lit);

	// Phase sequencer and fetch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_ff <= mcxs_pkg::QD;
			ir_ff    <= mcxs_pkg::OP_NOP;
			flush_ff <= 1'b0;
			pc_ff    <= mcxs_pkg::PC_RST;
		end else if (do_swrst) begin
			phase_ff <= mcxs_pkg::QD;
			ir_ff    <= mcxs_pkg::OP_NOP;
			flush_ff <= 1'b0;
			pc_ff    <= mcxs_pkg::PC_RST;
		end else begin
			phase_ff <= mcxs_pkg::mcxs_phase_type'(phase_ff + 2'h1);
			if (in_q1) begin
				ir_ff <= next_ir;
			end
			if (in_q4) begin
				flush_ff <= is_two_cyc;
				if (is_relative_call_op) begin
					pc_ff <= call_tgt;
				end else if (is_int_ret || is_ret_lit) begin
					pc_ff <= stack_top_entry;
				end else if (!flush_ff) begin
					pc_ff <= ret_addr;
				end
			end
		end
	end

	// Return stack pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sp_ff <= mcxs_pkg::SP_RST;
		end else if (do_swrst) begin
			sp_ff <= mcxs_pkg::SP_RST;
		end else if (stk_push) begin
			sp_ff <= sp_ff + 5'h01;
		end else if (stk_pop3 || stk_pop4) begin
			sp_ff <= sp_ff - 5'h01;
		end
	end

	// Entries hold no reset: the pointer alone defines what is live
	always_ff @(posedge clk) begin
		if (stk_push) begin
			stack_mem[sp_ff + 5'h01] <= ret_addr;
		end
	end

	// Data memory access: address in Q2, sample at end of Q2, write strobe across Q4
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dmem_ff <= '0;
			opnd_ff <= 8'h00;
		end else if (do_swrst) begin
			dmem_ff <= '0;
			opnd_ff <= 8'h00;
		end else begin
			if (in_q1) begin
				dmem_ff.addr <= file_addr(insn, bsr_ff, ext_set_en, index_base);
			end
			if (in_q2) begin
				opnd_ff <= dmem_rdata;
			end
			if (in_q3 && is_neg) begin
				dmem_ff.wdata <= neg_res;
				dmem_ff.we    <= 1'b1;
			end else if (in_q4) begin
				dmem_ff.we    <= 1'b0;
			end
		end
	end

	// Process results and register write-back
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mul_ff         <= mcxs_pkg::PROD_RST;
			flags_ff       <= mcxs_pkg::STATUS_RST;
			prod_ff        <= mcxs_pkg::PROD_RST;
			w_ff           <= mcxs_pkg::W_RST;
			status_ff      <= mcxs_pkg::STATUS_RST;
			bsr_ff         <= mcxs_pkg::BSR_RST;
			high_irq_en_ff <= 1'b0;
			low_irq_en_ff  <= 1'b0;
		end else if (do_swrst) begin
			mul_ff         <= mcxs_pkg::PROD_RST;
			flags_ff       <= mcxs_pkg::STATUS_RST;
			prod_ff        <= mcxs_pkg::PROD_RST;
			w_ff           <= mcxs_pkg::W_RST;
			status_ff      <= mcxs_pkg::STATUS_RST;
			bsr_ff         <= mcxs_pkg::BSR_RST;
			high_irq_en_ff <= 1'b0;
			low_irq_en_ff  <= 1'b0;
		end else begin
			if (in_q3) begin
				mul_ff   <= mul_prod;
				flags_ff <= neg_flags;
			end
			if (in_q4) begin
				if (is_mul_lit || is_mul_reg) begin
					prod_ff <= mul_ff;
				end
				if (is_neg) begin
					status_ff <= flags_ff;
				end
				if (is_ret_lit) begin
					w_ff <= ir_ff[7:0];
				end
				if (is_int_ret) begin
					if (exit_high_prio) begin
						high_irq_en_ff <= 1'b1;
					end else begin
						low_irq_en_ff <= 1'b1;
					end
					if (fast_ret) begin
						w_ff      <= shadow.w;
						status_ff <= shadow.status;
						bsr_ff    <= shadow.bank_select_reg;
					end
				end
			end
		end
	end

	// One-clock marker of the software reset for the rest of the chip
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sw_reset_ff <= 1'b0;
		end else begin
			sw_reset_ff <= do_swrst;
		end
	end
endmodule
`default_nettype wire

// file: testbench/mcxs_core_asserts.sv
// Property checker for the instruction execute subset
`timescale 1ns/1ps
`default_nettype none
module mcxs_core_asserts (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rstn,
	// Program and data side
	input wire logic [15:0]              insn,
	input wire logic [20:0]              pc_ff,
	input wire mcxs_pkg::mcxs_dmem_type  dmem_ff,
	input wire logic [7:0]               dmem_rdata,
	input wire logic                     ext_set_en,
	input wire logic [11:0]              index_base,
	// Core state
	input wire logic [7:0]               w_ff,
	input wire logic [15:0]              prod_ff,
	input wire logic [4:0]               status_ff,
	input wire logic [3:0]               bsr_ff,
	input wire logic                     sw_reset_ff,
	input wire mcxs_pkg::mcxs_phase_type phase_ff
);
	logic        idle_ff;
	wire logic   qd = phase_ff == mcxs_pkg::QD;
	wire logic   take = qd && !idle_ff;
	wire logic [7:0] f = insn[7:0];
	wire logic   neg = take && insn[15:9] == mcxs_pkg::OP_NEG_REG;
	wire logic   mulr = take && insn[15:9] == mcxs_pkg::OP_MUL_REG;
	wire logic   idx = ext_set_en && !insn[8] && f <= 8'h5F;
	wire logic   two = insn[15:11] == mcxs_pkg::OP_REL_CALL || insn[15:8] == mcxs_pkg::OP_RET_LIT;
	wire logic   two_cyc = two || insn[15:1] == mcxs_pkg::OP_INT_RET;
	wire logic [11:0] bank_addr = insn[8] ? {bsr_ff, f} : {f < 8'h60 ? 4'h0 : 4'hF, f};
	wire logic [20:0] off = {{9{insn[10]}}, insn[10:0], 1'b0};
	// Tracks the idle second cycle so its ignored word never arms a property
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) idle_ff <= 1'b0;
		else if (qd) idle_ff <= take && two_cyc;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	phase_order_a: assert property (qd |=> phase_ff == mcxs_pkg::QR)
		else $error("phase order broken");
	mul_lit_a: assert property (take && insn[15:8] == mcxs_pkg::OP_MUL_LIT |-> ##4
		prod_ff == $past(w_ff, 4) * $past(f, 4) && status_ff == $past(status_ff, 4)
		&& w_ff == $past(w_ff, 4)) else $error("literal product wrong");
	mul_reg_a: assert property (mulr |-> ##4
		prod_ff == $past(w_ff, 4) * $past(dmem_rdata, 3) && status_ff == $past(status_ff, 4))
		else $error("register product wrong");
	neg_write_a: assert property (neg |-> ##1 !dmem_ff.we [*2] ##1 (dmem_ff.we
		&& dmem_ff.wdata == 8'h00 - $past(dmem_rdata, 2)) ##1 !dmem_ff.we)
		else $error("negate write wrong");
	neg_zero_a: assert property (neg |-> ##4 status_ff[mcxs_pkg::FLAG_Z] ==
		($past(dmem_rdata, 3) == 8'h00)) else $error("negate zero flag wrong");
	addr_sel_a: assert property ((neg || mulr) && !idx |=>
		dmem_ff.addr == $past(bank_addr)) else $error("bank address wrong");
	indexed_addr_a: assert property ((neg || mulr) && idx |=>
		dmem_ff.addr == $past(index_base) + {4'h0, $past(f)}) else $error("indexed address wrong");
	nop_hold_a: assert property (take && (insn == mcxs_pkg::OP_NOP
		|| insn[15:12] == mcxs_pkg::OP_NOP_HI) |-> ##4 pc_ff == $past(pc_ff, 4) + 21'h00_0002
		&& w_ff == $past(w_ff, 4) && status_ff == $past(status_ff, 4))
		else $error("no-op changed state");
	call_target_a: assert property (take && insn[15:11] == mcxs_pkg::OP_REL_CALL |-> ##4
		pc_ff == $past(pc_ff, 4) + 21'h00_0002 + $past(off, 4) ##1 $stable(pc_ff) [*3])
		else $error("relative call target wrong");
	sw_reset_a: assert property (take && insn == mcxs_pkg::OP_SW_RESET |-> ##2
		sw_reset_ff && qd && pc_ff == 21'h00_0000 && w_ff == 8'h00 && bsr_ff == 4'h0
		##1 !sw_reset_ff) else $error("software reset wrong");
	ret_lit_a: assert property (take && insn[15:8] == mcxs_pkg::OP_RET_LIT |-> ##4
		w_ff == $past(f, 4)) else $error("literal return wrong");
	cover property (neg);
	cover property (take && two_cyc);
	cover property (take && insn == mcxs_pkg::OP_SW_RESET);
endmodule
bind mcxs_core mcxs_core_asserts u_mcxs_core_asserts (.clk, .rstn, .insn, .pc_ff, .dmem_ff,
	.dmem_rdata, .ext_set_en, .index_base, .w_ff, .prod_ff, .status_ff, .bsr_ff, .sw_reset_ff,
	.phase_ff);
`default_nettype wire

// file: testbench/mcxs_core_tb.sv
// Self-checking bench for the instruction execute subset
`timescale 1ns/1ps
`default_nettype none
module mcxs_core_tb;
	logic                      clk = 1'b0;
	logic                      rstn = 1'b0;
	logic [15:0]               insn = 16'h0000;
	logic [7:0]                dmem_rdata = 8'h00;
	logic                      ext_set_en = 1'b0;
	logic [11:0]               index_base = 12'h0200;
	mcxs_pkg::mcxs_shadow_type shadow = '0;
	logic                      exit_high_prio = 1'b0;
	logic [20:0]               pc_ff;
	mcxs_pkg::mcxs_dmem_type   dmem_ff;
	logic [7:0]                w_ff;
	logic [15:0]               prod_ff;
	logic [4:0]                status_ff;
	logic [3:0]                bsr_ff;
	logic                      high_irq_en_ff;
	logic                      low_irq_en_ff;
	logic                      sw_reset_ff;
	mcxs_pkg::mcxs_phase_type  phase_ff;
	int                        n_errors = 0;
	int                        compares = 0;
	int                        cycles = 0;
	mcxs_core u_mcxs_core (.clk, .rstn, .insn, .pc_ff, .dmem_ff, .dmem_rdata, .ext_set_en,
		.index_base, .shadow, .exit_high_prio, .w_ff, .prod_ff, .status_ff, .bsr_ff,
		.high_irq_en_ff, .low_irq_en_ff, .sw_reset_ff, .phase_ff);
	initial forever #4 clk = ~clk;
	task automatic end_of_test;
		if (n_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 2000) begin
			n_errors++;
			end_of_test;
		end
	end
	task automatic chk(input string s, input logic [20:0] e, input logic [20:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// Called just after an edge; the core is in decode except for the later calls inside t_neg
	task automatic step(input logic [15:0] word, input logic [7:0] rd, input int n);
		insn = word;
		dmem_rdata = rd;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic t_stack;
		step(mcxs_pkg::OP_PUSH, 8'h00, 4);
		step(mcxs_pkg::OP_PUSH, 8'h00, 4);
		step(mcxs_pkg::OP_POP, 8'h00, 4);
		step(16'h0CE2, 8'h00, 8);
		chk("pc", 21'h00_0002, pc_ff);
		chk("w", 21'(8'hE2), 21'(w_ff));
	endtask
	task automatic t_ret;
		shadow = {8'h5A, 5'h1F, 4'h3};
		exit_high_prio = 1'b1;
		step(mcxs_pkg::OP_PUSH, 8'h00, 4);
		step(16'h0011, 8'h00, 8);
		chk("pc", 21'h00_0004, pc_ff);
		chk("high_en", 21'(1'b1), 21'(high_irq_en_ff));
		chk("flags", 21'(5'h1F), 21'(status_ff));
		chk("bsr", 21'(4'h3), 21'(bsr_ff));
		shadow = '0;
		exit_high_prio = 1'b0;
		step(mcxs_pkg::OP_PUSH, 8'h00, 4);
		step(16'h0010, 8'h00, 8);
		chk("low_en", 21'(1'b1), 21'(low_irq_en_ff));
		chk("w", 21'(8'h5A), 21'(w_ff));
	endtask
	task automatic t_mul;
		step(16'h0DC4, 8'h00, 4);
		chk("prod", 21'(16'h005A * 16'h00C4), 21'(prod_ff));
		chk("flags", 21'(5'h1F), 21'(status_ff));
		step(16'h0305, 8'hB5, 4);
		chk("prod", 21'(16'h005A * 16'h00B5), 21'(prod_ff));
		chk("w", 21'(8'h5A), 21'(w_ff));
	endtask
	task automatic t_neg(input logic [15:0] word, input logic [7:0] rd, input logic [11:0] a,
		input logic [4:0] f);
		step(word, rd, 1);
		chk("addr", 21'(a), 21'(dmem_ff.addr));
		step(word, rd, 2);
		chk("we", 21'(1'b1), 21'(dmem_ff.we));
		chk("wdata", {13'h0000, 8'h00 - rd}, 21'(dmem_ff.wdata));
		step(word, rd, 1);
		chk("we", 21'(1'b0), 21'(dmem_ff.we));
		chk("flags", 21'(f), 21'(status_ff));
	endtask
	task automatic t_call(input logic [15:0] word, input logic [20:0] off);
		logic [20:0] p;
		p = pc_ff;
		step(word, 8'h00, 4);
		chk("pc", p + 21'h00_0002 + off, pc_ff);
		step(16'h0D02, 8'h00, 4);
		chk("pc", p + 21'h00_0002 + off, pc_ff);
		chk("prod", 21'(16'h005A * 16'h00B5), 21'(prod_ff));
		step(16'h0C77, 8'h00, 8);
		chk("pc", p + 21'h00_0002, pc_ff);
	endtask
	task automatic t_nop;
		step(16'hF123, 8'h00, 4);
		chk("pc", 21'h00_0016, pc_ff);
		chk("w", 21'(8'h77), 21'(w_ff));
		chk("flags", 21'(5'h1A), 21'(status_ff));
	endtask
	task automatic t_reset;
		step(mcxs_pkg::OP_SW_RESET, 8'h00, 2);
		chk("sw_reset", 21'(1'b1), 21'(sw_reset_ff));
		chk("pc", 21'h00_0000, pc_ff);
		chk("prod", 21'(16'h0000), 21'(prod_ff));
		chk("flags", 21'(5'h00), 21'(status_ff));
		chk("w", 21'(8'h00), 21'(w_ff));
		chk("bsr", 21'(4'h0), 21'(bsr_ff));
		chk("high_en", 21'(1'b0), 21'(high_irq_en_ff));
		chk("low_en", 21'(1'b0), 21'(low_irq_en_ff));
		// The reset word must leave the bus before the next decode edge, or it fires again
		step(mcxs_pkg::OP_NOP, 8'h00, 2);
		chk("sw_reset", 21'(1'b0), 21'(sw_reset_ff));
		chk("pc", 21'h00_0000, pc_ff);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_stack;
		t_ret;
		t_mul;
		t_neg(16'h6D22, 8'h3A, 12'h322, 5'h10);
		t_neg(16'h6C70, 8'h00, 12'hF70, 5'h07);
		ext_set_en = 1'b1;
		t_neg(16'h6C10, 8'h80, 12'h210, 5'h1A);
		ext_set_en = 1'b0;
		t_call(16'hDBFF, 21'h00_07FE);
		t_call(16'hDFFF, 21'h1F_FFFE);
		t_nop;
		t_reset;
		end_of_test;
	end
endmodule
`default_nettype wire
